// ==== design/hcs_pkg.sv ====
// Package of constants and types for the hub configuration source selector
package hcs_pkg;

   // ==========================================================
   // Strap decode of the configuration source
   typedef enum logic [1:0] {
      HCS_SRC_RSVD    = 2'h0,
      HCS_SRC_SMBUS   = 2'h1,
      HCS_SRC_DEFAULT = 2'h2,
      HCS_SRC_EEPROM  = 2'h3
   } hcs_src_t;

   // ==========================================================
   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      HCS_ST_SETTLE = 4'h1,
      HCS_ST_LOAD   = 4'h2,
      HCS_ST_READY  = 4'h4,
      HCS_ST_HALT   = 4'h8
   } hcs_state_t;

   // ==========================================================
   // Field widths, counts and the SMBus slave address
   localparam int          ID_W          = 16;
   localparam int          NUM_PORTS     = 7;
   localparam int          TT_BUF_W      = 3;
   localparam logic [2:0]  TT_NP_BUFS    = 3'h4;
   localparam logic [6:0]  SMBUS_ADDR    = 7'h2c;

   // ==========================================================
   // Built-in default identity values (arbitrary, neutral values)
   localparam logic [15:0] DEF_VID       = 16'h1234;
   localparam logic [15:0] DEF_PID       = 16'h5678;
   localparam logic [15:0] DEF_DID       = 16'h0100;

   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_ID        = 16'h0000;

   // ==========================================================
   // Timing
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          SYNC_STAGES   = 2;
   localparam logic [1:0]  SETTLE_CYCLES = 2'h2;
   localparam int          RESET_MIN_NS  = 1000;
   localparam int          RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== design/hcs_sync_if.sv ====
// Interface carrying synchronised pin levels between the selector modules
`timescale 1ns/1ps
interface hcs_sync_if #(
   parameter int W = 3
);
   logic [W-1:0] level;

   modport src (output level);
   modport dst (input  level);
endinterface

// ==== design/hcs_pin_sync.sv ====
// Two-stage synchroniser for the strap and power detect pins
`timescale 1ns/1ps
module hcs_pin_sync #(
   parameter int W = 3
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] pin_raw,
   hcs_sync_if.src           sync
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] stab_r;
   logic [W-1:0] stab_nxt;

   // ==========================================================
   // Next values, first stage read only by second stage
   always_comb begin
      meta_nxt = pin_raw; // No reset gate ahead of the first flop
      stab_nxt = meta_r;
      if (!resetn) begin
         stab_nxt = '0;
      end
   end

   // Register stages
   always_ff @(posedge mclk) begin
      meta_r <= meta_nxt;
      stab_r <= stab_nxt;
   end

   assign sync.level = stab_r;

endmodule

// ==== design/hcs_top.sv ====
// Configuration source selector and identity/power reporter of the hub
`timescale 1ns/1ps
module hcs_top #(
   parameter logic [15:0] DEFAULT_VID = hcs_pkg::DEF_VID,
   parameter logic [15:0] DEFAULT_PID = hcs_pkg::DEF_PID,
   parameter logic [15:0] DEFAULT_DID = hcs_pkg::DEF_DID,
   parameter int          NUM_PORTS   = hcs_pkg::NUM_PORTS
) (
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic                          config_source_sel_hi,
   input  wire logic                          config_source_sel_lo,
   input  wire logic                          local_power_detect,
   input  wire logic                          load_done,
   input  wire logic [hcs_pkg::ID_W-1:0]      load_vid,
   input  wire logic [hcs_pkg::ID_W-1:0]      load_pid,
   input  wire logic [hcs_pkg::ID_W-1:0]      load_did,
   input  wire logic                          load_self_powered,
   output logic                               smbus_load_req,
   output logic                               eeprom_load_req,
   output logic [6:0]                         smbus_slave_addr,
   output logic [1:0]                         config_source,
   output logic                               config_source_valid,
   output logic                               strap_reserved,
   output logic                               hub_configured,
   output logic                               upstream_attach_en,
   output logic [hcs_pkg::ID_W-1:0]           vendor_id,
   output logic [hcs_pkg::ID_W-1:0]           product_id,
   output logic [hcs_pkg::ID_W-1:0]           device_release,
   output logic                               self_powered,
   output logic [NUM_PORTS-1:0]               port_available,
   output logic [NUM_PORTS-1:0]               tt_enable,
   output logic [hcs_pkg::TT_BUF_W-1:0]       tt_nonperiodic_bufs
);

   // ==========================================================
   // Pin synchronisation
   hcs_sync_if #(.W(3)) pins_if ();

   hcs_pin_sync #(
      .W (3)
   ) u_sync (
      .mclk    (mclk),
      .resetn  (resetn),
      .pin_raw ({config_source_sel_hi, config_source_sel_lo, local_power_detect}),
      .sync    (pins_if)
   );

   logic [1:0] strap_sync;
   logic       pwr_sync;

   assign strap_sync = pins_if.level[2:1];
   assign pwr_sync   = pins_if.level[0];

   // ==========================================================
   // State
   hcs_pkg::hcs_state_t         state_r;
   hcs_pkg::hcs_state_t         state_nxt;
   hcs_pkg::hcs_src_t           src_r;
   hcs_pkg::hcs_src_t           src_nxt;
   logic [1:0]                  settle_r;
   logic [1:0]                  settle_nxt;
   logic                        src_valid_r;
   logic                        src_valid_nxt;
   logic                        cfgd_r;
   logic                        cfgd_nxt;
   logic                        rsvd_r;
   logic                        rsvd_nxt;
   logic [hcs_pkg::ID_W-1:0]    vid_r;
   logic [hcs_pkg::ID_W-1:0]    vid_nxt;
   logic [hcs_pkg::ID_W-1:0]    pid_r;
   logic [hcs_pkg::ID_W-1:0]    pid_nxt;
   logic [hcs_pkg::ID_W-1:0]    did_r;
   logic [hcs_pkg::ID_W-1:0]    did_nxt;
   logic                        ld_spwr_r;
   logic                        ld_spwr_nxt;
   logic                        spwr_r;
   logic                        spwr_nxt;
   logic [NUM_PORTS-1:0]        ports_r;
   logic [NUM_PORTS-1:0]        ports_nxt;
   logic [NUM_PORTS-1:0]        tt_r;
   logic [NUM_PORTS-1:0]        tt_nxt;

   // Decode of the strap pair into a source
   function automatic hcs_pkg::hcs_src_t decode_src(input logic [1:0] s);
      hcs_pkg::hcs_src_t d;
      d = hcs_pkg::hcs_src_t'(s);
      return d;
   endfunction

   // ==========================================================
   // Sequencer: settle, latch, load, ready
   always_comb begin
      state_nxt     = state_r;
      src_nxt       = src_r;
      settle_nxt    = settle_r;
      src_valid_nxt = src_valid_r;
      cfgd_nxt      = cfgd_r;
      rsvd_nxt      = rsvd_r;
      vid_nxt       = vid_r;
      pid_nxt       = pid_r;
      did_nxt       = did_r;
      ld_spwr_nxt   = ld_spwr_r;
      unique case (state_r)
         hcs_pkg::HCS_ST_SETTLE: begin
            // Wait for synchroniser to hold post-release pin levels
            if (settle_r == hcs_pkg::SETTLE_CYCLES) begin
               src_nxt       = decode_src(strap_sync);
               src_valid_nxt = 1'b1;
               unique case (decode_src(strap_sync))
                  hcs_pkg::HCS_SRC_RSVD: begin
                     rsvd_nxt  = 1'b1;
                     state_nxt = hcs_pkg::HCS_ST_HALT;
                  end
                  hcs_pkg::HCS_SRC_DEFAULT: begin
                     vid_nxt   = DEFAULT_VID;
                     pid_nxt   = DEFAULT_PID;
                     did_nxt   = DEFAULT_DID;
                     cfgd_nxt  = 1'b1;
                     state_nxt = hcs_pkg::HCS_ST_READY;
                  end
                  hcs_pkg::HCS_SRC_SMBUS,
                  hcs_pkg::HCS_SRC_EEPROM: begin
                     state_nxt = hcs_pkg::HCS_ST_LOAD;
                  end
               endcase
            end else begin
               settle_nxt = 2'(settle_r + 2'h1);
            end
         end
         hcs_pkg::HCS_ST_LOAD: begin
            // Capture the downloaded identity and power fields
            if (load_done) begin
               vid_nxt     = load_vid;
               pid_nxt     = load_pid;
               did_nxt     = load_did;
               ld_spwr_nxt = load_self_powered;
               cfgd_nxt    = 1'b1;
               state_nxt   = hcs_pkg::HCS_ST_READY;
            end
         end
         hcs_pkg::HCS_ST_READY: begin
            state_nxt = hcs_pkg::HCS_ST_READY;
         end
         hcs_pkg::HCS_ST_HALT: begin
            state_nxt = hcs_pkg::HCS_ST_HALT;
         end
         default: begin
            state_nxt = hcs_pkg::HCS_ST_SETTLE;
         end
      endcase
      if (!resetn) begin
         state_nxt     = hcs_pkg::HCS_ST_SETTLE;
         src_nxt       = hcs_pkg::HCS_SRC_RSVD;
         settle_nxt    = 2'h0;
         src_valid_nxt = 1'b0;
         cfgd_nxt      = 1'b0;
         rsvd_nxt      = 1'b0;
         vid_nxt       = hcs_pkg::RST_ID;
         pid_nxt       = hcs_pkg::RST_ID;
         did_nxt       = hcs_pkg::RST_ID;
         ld_spwr_nxt   = 1'b0;
      end
   end

   // Register sequencer state
   always_ff @(posedge mclk) begin
      state_r     <= state_nxt;
      src_r       <= src_nxt;
      settle_r    <= settle_nxt;
      src_valid_r <= src_valid_nxt;
      cfgd_r      <= cfgd_nxt;
      rsvd_r      <= rsvd_nxt;
      vid_r       <= vid_nxt;
      pid_r       <= pid_nxt;
      did_r       <= did_nxt;
      ld_spwr_r   <= ld_spwr_nxt;
   end

   // ==========================================================
   // Power status, port availability and translators
   always_comb begin
      spwr_nxt  = 1'b0;
      ports_nxt = '0;
      tt_nxt    = '0;
      if (cfgd_r) begin
         // High detect level means a local supply is present
         if (src_r == hcs_pkg::HCS_SRC_DEFAULT) begin
            spwr_nxt = pwr_sync;
         end else begin
            spwr_nxt = ld_spwr_r;
         end
         if (spwr_r) begin
            ports_nxt = '1;
         end else begin
            ports_nxt = '1;
         end
         tt_nxt = '1;
      end
      if (!resetn) begin
         spwr_nxt  = 1'b0;
         ports_nxt = '0;
         tt_nxt    = '0;
      end
   end

   // Register power and port outputs
   always_ff @(posedge mclk) begin
      spwr_r  <= spwr_nxt;
      ports_r <= ports_nxt;
      tt_r    <= tt_nxt;
   end

   // ==========================================================
   // Outputs
   assign smbus_load_req      = (state_r == hcs_pkg::HCS_ST_LOAD) &&
                                (src_r == hcs_pkg::HCS_SRC_SMBUS);
   assign eeprom_load_req     = (state_r == hcs_pkg::HCS_ST_LOAD) &&
                                (src_r == hcs_pkg::HCS_SRC_EEPROM);
   assign smbus_slave_addr    = hcs_pkg::SMBUS_ADDR;
   assign config_source       = src_r;
   assign config_source_valid = src_valid_r;
   assign strap_reserved      = rsvd_r;
   assign hub_configured      = cfgd_r;
   assign upstream_attach_en  = cfgd_r;
   assign vendor_id           = vid_r;
   assign product_id          = pid_r;
   assign device_release      = did_r;
   assign self_powered        = spwr_r;
   assign port_available      = ports_r;
   assign tt_enable           = tt_r;
   assign tt_nonperiodic_bufs = hcs_pkg::TT_NP_BUFS;

endmodule

// ==== test/hcs_chk_assertions.sv ====
// Port checker of the configuration source selector
`timescale 1ns/1ps
module hcs_chk #(
   parameter logic [15:0] DEFAULT_VID = 16'h0000,
   parameter int          NUM_PORTS   = 7
) (
   input wire logic                 mclk,
   input wire logic                 resetn,
   input wire logic                 config_source_sel_hi,
   input wire logic                 config_source_sel_lo,
   input wire logic                 local_power_detect,
   input wire logic                 load_done,
   input wire logic [15:0]          load_vid,
   input wire logic                 load_self_powered,
   input wire logic                 smbus_load_req,
   input wire logic                 eeprom_load_req,
   input wire logic [1:0]           config_source,
   input wire logic                 config_source_valid,
   input wire logic                 strap_reserved,
   input wire logic                 hub_configured,
   input wire logic                 upstream_attach_en,
   input wire logic [15:0]          vendor_id,
   input wire logic                 self_powered,
   input wire logic [NUM_PORTS-1:0] port_available
);
   logic [1:0] strap;
   logic       req;
   // Strap code and pending download
   assign strap = {config_source_sel_hi, config_source_sel_lo};
   assign req   = smbus_load_req | eeprom_load_req;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Sequences
   sequence s_rel;
      $rose(resetn);
   endsequence
   sequence s_take;
      req && load_done;
   endsequence
   // ==========================================================
   // Properties
   property p_attach;
      upstream_attach_en |-> hub_configured && config_source_valid && !strap_reserved;
   endproperty
   a_attach: assert property (p_attach) else $error("attach while unconfigured");
   property p_latch;
      s_rel |=> !config_source_valid [*2] ##1
         (config_source_valid && config_source == $past(strap, 3));
   endproperty
   a_latch: assert property (p_latch) else $error("strap latch wrong");
   property p_hold;
      config_source_valid |=> config_source_valid && $stable(config_source);
   endproperty
   a_hold: assert property (p_hold) else $error("source changed");
   property p_reserved;
      config_source_valid |-> strap_reserved == (config_source == 2'h0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved flag wrong");
   property p_req;
      req |-> !hub_configured && smbus_load_req == (config_source == 2'h1)
         && eeprom_load_req == (config_source == 2'h3);
   endproperty
   a_req: assert property (p_req) else $error("load request wrong");
   property p_load;
      s_take |=> hub_configured && vendor_id == $past(load_vid) ##1
         (self_powered == $past(load_self_powered, 2) && port_available == '1);
   endproperty
   a_load: assert property (p_load) else $error("loaded values wrong");
   property p_default;
      $rose(config_source_valid) && config_source == 2'h2 |->
         hub_configured && vendor_id == DEFAULT_VID;
   endproperty
   a_default: assert property (p_default) else $error("default id wrong");
   property p_pwr;
      (hub_configured && config_source == 2'h2) [*4] |->
         self_powered == $past(local_power_detect, 3);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power status wrong");
endmodule
bind hcs_top hcs_chk #(.DEFAULT_VID(DEFAULT_VID), .NUM_PORTS(NUM_PORTS)) u_chk (
   .mclk, .resetn, .config_source_sel_hi, .config_source_sel_lo, .local_power_detect,
   .load_done, .load_vid, .load_self_powered, .smbus_load_req, .eeprom_load_req,
   .config_source, .config_source_valid, .strap_reserved, .hub_configured,
   .upstream_attach_en, .vendor_id, .self_powered, .port_available
);

// ==== test/hcs_load_model.sv ====
// Download engine model standing in for the SMBus host or EEPROM
`timescale 1ns/1ps
module hcs_load_model (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        smbus_load_req,
   input  wire logic        eeprom_load_req,
   input  wire logic [7:0]  wait_cyc,
   input  wire logic [15:0] seed_val,
   output logic             load_done,
   output logic [15:0]      load_vid,
   output logic [15:0]      load_pid,
   output logic [15:0]      load_did,
   output logic             load_self_powered
);
   logic [7:0]  cnt_r;
   logic [15:0] inv;
   // One pulse after wait_cyc+1 cycles of a pending request
   always_ff @(posedge mclk) begin
      load_done <= 1'b0;
      if (!resetn) begin
         cnt_r <= 8'h00;
      end else if ((smbus_load_req || eeprom_load_req) && !load_done) begin
         cnt_r     <= cnt_r + 8'h01;
         load_done <= (cnt_r == wait_cyc);
      end
   end
   // Fields valid in the pulse cycle only, inverted otherwise
   assign inv               = load_done ? 16'h0000 : 16'hffff;
   assign load_vid          = seed_val ^ inv;
   assign load_pid          = ~seed_val ^ inv;
   assign load_did          = seed_val ^ 16'h0101 ^ inv;
   assign load_self_powered = seed_val[0] ^ inv[0];
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench of the configuration source selector
`timescale 1ns/1ps
module tb_top;
   logic        mclk, resetn, config_source_sel_hi, config_source_sel_lo, local_power_detect;
   logic        load_done, load_self_powered, smbus_load_req, eeprom_load_req, self_powered;
   logic        config_source_valid, strap_reserved, hub_configured, upstream_attach_en;
   logic [1:0]  config_source;
   logic [2:0]  tt_nonperiodic_bufs;
   logic [6:0]  smbus_slave_addr, port_available, tt_enable;
   logic [7:0]  wait_cyc;
   logic [15:0] load_vid, load_pid, load_did, vendor_id, product_id, device_release, seed_val;
   int          num_errors, comparisons, cycles;
   hcs_top uut (.*);
   hcs_load_model u_model (.*);
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         give_verdict();
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic give_verdict();
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic do_reset(input logic [1:0] s, input int n);
      @(negedge mclk);
      resetn = 1'b0;
      {config_source_sel_hi, config_source_sel_lo} = s;
      repeat (n) @(negedge mclk);
      resetn = 1'b1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_default();
      do_reset(2'h2, 2);
      repeat (6) @(negedge mclk);
      chk(config_source, 2'h2);
      chk(vendor_id, hcs_pkg::DEF_VID);
      chk(product_id, hcs_pkg::DEF_PID);
      chk(device_release, hcs_pkg::DEF_DID);
      chk(self_powered, 1'b1);
      chk(port_available, 7'h7f);
      chk({tt_enable, tt_nonperiodic_bufs}, {7'h7f, 3'h4});
      chk(smbus_slave_addr, 7'h2c);
      chk(upstream_attach_en, 1'b1);
      local_power_detect = 1'b0;
      {config_source_sel_hi, config_source_sel_lo} = 2'h1;
      repeat (4) @(negedge mclk);
      chk(self_powered, 1'b0);
      chk({config_source_valid, config_source}, 3'h6);
   endtask
   task automatic t_load(input logic [1:0] s, input logic [7:0] w, input logic [15:0] v);
      int i;
      wait_cyc = w;
      seed_val = v;
      do_reset(s, 50);
      repeat (4) @(negedge mclk);
      chk({smbus_load_req, eeprom_load_req}, {s == 2'h1, s == 2'h3});
      chk(upstream_attach_en, 1'b0);
      for (i = 0; i < 100 && hub_configured !== 1'b1; i++) begin
         @(negedge mclk);
      end
      @(negedge mclk);
      chk(vendor_id, v);
      chk(product_id, ~v);
      chk(device_release, v ^ 16'h0101);
      chk(self_powered, v[0]);
      chk(port_available, 7'h7f);
      chk(upstream_attach_en, 1'b1);
   endtask
   task automatic t_reserved();
      do_reset(2'h0, 50);
      repeat (8) @(negedge mclk);
      chk({strap_reserved, config_source_valid, config_source}, 4'hc);
      chk({hub_configured, upstream_attach_en}, 2'h0);
      chk({smbus_load_req, eeprom_load_req}, 2'h0);
   endtask
   // Main sequence
   initial begin
      resetn               = 1'b0;
      config_source_sel_hi = 1'b1;
      config_source_sel_lo = 1'b0;
      local_power_detect   = 1'b1;
      wait_cyc             = 8'h00;
      seed_val             = 16'h0000;
      num_errors           = 0;
      comparisons          = 0;
      cycles               = 0;
      t_default();
      t_load(2'h1, 8'h00, 16'h0210);
      t_load(2'h3, 8'h14, 16'h4567);
      t_reserved();
      give_verdict();
   end
endmodule
